// ==== line_mode_map.svh ====
// Function
// RULE1: Leased-line operation starts only when the leased-line command appears in the line. The code keeps ll_q set across lines until defaults or reset.
// RULE2: Leased-line operation goes straight to data mode with no handshake.
// RULE3: Leased-line works with every supported modulation mode.
// RULE4: Host dials one modem, answers the other; each sends carrier and seeks remote carrier.
// RULE5: With hang-up-on-toggle, a terminal-ready toggle sends OK, then carrier stops.
// RULE6: Host should enable retrain response and auto-retrain requests for V.22bis leased-line.
// RULE7: Retrain request threshold is programmable; V.22bis leased-line setup uses 12.
// RULE8: Modulation select: 4 V.22bis, 8 V.22, 16 Bell 212, 32 Bell 103, 64 V.21.
// RULE9: Carrier detect selectable qualified or raw, raw following unqualified carrier.
// RULE10: Clear channel or speed buffered operation, with selectable hardware flow control.
// RULE11: Ring threshold is amplitude; 1..127 check frequency, 129..255 do not.
// RULE12: Ring threshold zero disables energy ring detection and uses optocoupler input.
// RULE13: Energy ring detection still applies ring frequency range and cadence timing.
// RULE14: Host should set ring threshold about seven with auto-answer on first ring.
// RULE15: Normal Type II caller ID active only with enable bit set and off hook.
// RULE16: On alerting tone send DTMF D, receive caller ID, then go on hook.
// RULE17: Caller ID control equal to 99 hex enables snoop reporting while on hook.
// RULE18: Snoop mode outputs handshake data from another device without participating.
// RULE19: Answer tone select enables 1650, 1300, 2100, 2225, 2250 Hz per bit.
// RULE20: After defaults answer tone select holds bits 0, 2, 4 and 5 only.
// RULE21: Country config write loads all country parameters; individual registers stay writable. The code loads the US preset for every country code.
// RULE22: Half-duplex gated mode turns carrier on 10 ms after request, off 5 ms after.
// RULE23: Each command line is parsed, settings applied in order, then dial or answer runs.
// RULE24: Reserved answer tone bits have no effect on detection.
`ifndef LINE_MODE_MAP_SVH
`define LINE_MODE_MAP_SVH
`define CLK_HZ 20000000
`define CARRIER_UP_MS 10
`define CARRIER_OFF_MS 5
`define CARRIER_UP_CYC ((`CLK_HZ / 1000) * `CARRIER_UP_MS)
`define CARRIER_OFF_CYC ((`CLK_HZ / 1000) * `CARRIER_OFF_MS)
`define REG_MODULATION 8'h1E
`define REG_RETRAIN_OPT 8'h1A
`define REG_RETRAIN_THR 8'h46
`define REG_CID_CTRL 8'h5F
`define REG_COUNTRY 8'h63
`define REG_CID_EXTRA 8'h6E
`define REG_ANS_TONE 8'h78
`define REG_RING_THR 8'h7B
`define REG_RING_FLO 8'h11
`define REG_RING_FHI 8'h12
`define REG_AUTO_ANS 8'h00
`define ANS_TONE_DEF 8'h35
`define ANS_TONE_VALID 8'h37
`define MOD_V22BIS 8'h04
`define MOD_V22 8'h08
`define MOD_B212 8'h10
`define MOD_B103 8'h20
`define MOD_V21 8'h40
`define MOD_DEF 8'h04
`define RETRAIN_THR_DEF 8'h14
`define RETRAIN_AUTO_BIT 2
`define CID_SNOOP 8'h99
`define CID_TYPE2_BIT 3
`define RING_FREQ_OFF_BIT 7
`define RING_FLO_DEF 8'h0F
`define RING_FHI_DEF 8'h44
`define RING_THR_DEF 8'h00
`define COUNTRY_US 8'h01
`define DTMF_D 4'hD
`define RESP_OK 8'h4F
`define RESP_K 8'h4B
`define CHAR_CR 8'h0D
`endif

// ==== line_mode_pkg.sv ====
`default_nettype none
package line_mode_pkg;
   typedef enum logic [1:0] {CMD_NONE, CMD_DIAL, CMD_ANSWER} act_e;
   typedef enum logic [2:0] {L_IDLE, L_DATA, L_OK1, L_OK2, L_OKCR, L_DRAIN} link_e;
   typedef enum logic [1:0] {C_IDLE, C_TONE, C_MSG} cid_e;
endpackage
`default_nettype wire

// ==== modem_line_mode_control.sv ====
`include "line_mode_map.svh"
`default_nettype none
module modem_line_mode_control
   import line_mode_pkg::*;
(
   input wire logic ref_clk, // 20 MHz clock
   input wire logic sys_rst, // Sync reset, high
   input wire logic cmd_valid, // Decoded command item strobe
   input wire logic [3:0] cmd_kind, // 0 reg write,1 leased,2 dial,3 answer,4 eol,5 defaults,6 opt
   input wire logic [7:0] cmd_addr, // Register number or option code
   input wire logic [7:0] cmd_data, // Register value or option argument
   input wire logic dtr_pin, // Terminal ready pin
   input wire logic rts_pin, // Request to send pin
   input wire logic raw_carrier_pin, // Unqualified received carrier
   input wire logic qual_carrier, // Qualified carrier from the pump
   input wire logic opto_ring_pin, // Optocoupler ring input
   input wire logic ring_energy_ok, // Energy above threshold, cadence qualified; frequency comes from ring_freq_ok
   input wire logic ring_freq_ok, // Ring frequency within range
   input wire logic alert_tone, // Call waiting alerting tone detected
   input wire logic cid_msg_done, // Caller ID message received
   input wire logic off_hook_req, // Host asked off hook
   input wire logic rx_ready, // Receive output can take a char
   output logic data_mode, // In data mode
   output logic tx_carrier, // Transmit carrier enable
   output logic originate, // Calling side
   output logic carrier_detect, // Carrier indication to host
   output logic cts, // Clear to send
   output logic rx_valid, // Response char strobe
   output logic [7:0] rx_char, // Response char
   output logic hook_off, // Line off hook
   output logic dtmf_valid, // Send DTMF digit
   output logic [3:0] dtmf_digit, // Digit code
   output logic cid_report, // Caller ID data forwarded
   output logic ring_detect, // Qualified ring
   output logic ring_freq_check, // Frequency checking on
   output logic [7:0] tone_enable, // Answer tone detector enables
   output logic [7:0] modulation, // Modulation select
   output logic [7:0] retrain_thr, // Retrain threshold
   output logic auto_retrain, // Auto retrain request enable
   output logic respond_retrain, // Respond to retrain
   output logic [7:0] ring_lo, // Ring freq low bound
   output logic [7:0] ring_hi, // Ring freq high bound
   output logic [7:0] auto_answer_rings // Auto answer ring count
);
   localparam int UP_CYC = `CARRIER_UP_CYC;
   localparam int OFF_CYC = `CARRIER_OFF_CYC;

   function automatic logic is_reg(input logic [3:0] k, input logic [7:0] a, input logic [7:0] r);
      is_reg = (k == 4'h0) && (a == r);
   endfunction

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [7:0] ans_tone_q, ring_thr_q, mod_q, rthr_q, ropt_q, cid_q, cidx_q, country_q, rlo_q, rhi_q, rings_q;
   logic wr;
   assign wr = cmd_valid;
   always_ff @(posedge ref_clk) begin
      if (sys_rst || (wr && cmd_kind == 4'h5)) begin
         ans_tone_q <= `ANS_TONE_DEF; // [RULE20]
         ring_thr_q <= `RING_THR_DEF;
         mod_q <= `MOD_DEF;
         rthr_q <= `RETRAIN_THR_DEF;
         ropt_q <= 8'h00;
         cid_q <= 8'h00;
         cidx_q <= 8'h00;
         country_q <= `COUNTRY_US;
         rlo_q <= `RING_FLO_DEF;
         rhi_q <= `RING_FHI_DEF;
         rings_q <= 8'h00;
      end else if (wr) begin
         // Items arrive in line order, so later settings overwrite earlier ones
         if (is_reg(cmd_kind, cmd_addr, `REG_ANS_TONE)) ans_tone_q <= cmd_data & `ANS_TONE_VALID; // [RULE19] [RULE24]
         if (is_reg(cmd_kind, cmd_addr, `REG_RING_THR)) ring_thr_q <= cmd_data; // [RULE11]
         if (is_reg(cmd_kind, cmd_addr, `REG_MODULATION)) mod_q <= cmd_data; // [RULE8] [RULE23]
         if (is_reg(cmd_kind, cmd_addr, `REG_RETRAIN_THR)) rthr_q <= cmd_data; // [RULE7]
         if (is_reg(cmd_kind, cmd_addr, `REG_RETRAIN_OPT)) ropt_q <= cmd_data;
         if (is_reg(cmd_kind, cmd_addr, `REG_CID_CTRL)) cid_q <= cmd_data;
         if (is_reg(cmd_kind, cmd_addr, `REG_CID_EXTRA)) cidx_q <= cmd_data;
         if (is_reg(cmd_kind, cmd_addr, `REG_AUTO_ANS)) rings_q <= cmd_data;
         if (is_reg(cmd_kind, cmd_addr, `REG_RING_FLO)) rlo_q <= cmd_data; // [RULE21]
         if (is_reg(cmd_kind, cmd_addr, `REG_RING_FHI)) rhi_q <= cmd_data;
         if (is_reg(cmd_kind, cmd_addr, `REG_COUNTRY)) begin
            // Only the US preset is tabled here; other codes reuse it
            country_q <= cmd_data; // [RULE21]
            rlo_q <= `RING_FLO_DEF;
            rhi_q <= `RING_FHI_DEF;
            rthr_q <= `RETRAIN_THR_DEF;
            ans_tone_q <= `ANS_TONE_DEF;
         end
      end
   end

   // ----------------------------------------
   // Options (opt codes: 0 raw cd, 1 qual cd, 2 clear, 3 buffered, 4 hw flow, 5 hangup toggle,
   // 6 respond retrain, 7 half duplex gated)
   // ----------------------------------------
   logic raw_cd_q, clear_q, hwflow_q, hangup_q, resp_q, hdx_q;
   always_ff @(posedge ref_clk) begin
      if (sys_rst || (wr && cmd_kind == 4'h5)) begin
         raw_cd_q <= 1'b0;
         clear_q <= 1'b0;
         hwflow_q <= 1'b0;
         hangup_q <= 1'b0;
         resp_q <= 1'b0;
         hdx_q <= 1'b0;
      end else if (wr && cmd_kind == 4'h6) begin
         unique case (cmd_addr)
            8'h00: raw_cd_q <= 1'b1; // [RULE9]
            8'h01: raw_cd_q <= 1'b0;
            8'h02: clear_q <= 1'b1; // [RULE10]
            8'h03: clear_q <= 1'b0;
            8'h04: hwflow_q <= 1'b1;
            8'h05: hangup_q <= 1'b1;
            8'h06: resp_q <= 1'b1;
            8'h07: hdx_q <= 1'b1;
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [2:0] dtr_s, rts_s, raw_s, opto_s;
   logic dtr_f, rts_f, raw_f, opto_f;
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         dtr_s <= 3'h0;
         rts_s <= 3'h0;
         raw_s <= 3'h0;
         opto_s <= 3'h0;
         dtr_f <= 1'b0;
         rts_f <= 1'b0;
         raw_f <= 1'b0;
         opto_f <= 1'b0;
      end else begin
         dtr_s <= {dtr_s[1:0], dtr_pin};
         rts_s <= {rts_s[1:0], rts_pin};
         raw_s <= {raw_s[1:0], raw_carrier_pin};
         opto_s <= {opto_s[1:0], opto_ring_pin};
         if (dtr_s[1] == dtr_s[2]) dtr_f <= dtr_s[2];
         if (rts_s[1] == rts_s[2]) rts_f <= rts_s[2];
         if (raw_s[1] == raw_s[2]) raw_f <= raw_s[2];
         if (opto_s[1] == opto_s[2]) opto_f <= opto_s[2];
      end
   end
   logic dtr_prev;
   always_ff @(posedge ref_clk) begin
      if (sys_rst) dtr_prev <= 1'b0;
      else dtr_prev <= dtr_f;
   end

   // ----------------------------------------
   // Leased-line sequencing
   // ----------------------------------------
   link_e link_q;
   logic ll_q, orig_q, carrier_q;
   logic [17:0] gate_cnt_q;
   logic gate_up_q;
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ll_q <= 1'b0;
      end else if (wr && cmd_kind == 4'h1) begin
         ll_q <= 1'b1; // [RULE1]
      end else if (wr && cmd_kind == 4'h5) begin
         ll_q <= 1'b0;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         link_q <= L_IDLE;
         orig_q <= 1'b0;
         rx_valid <= 1'b0;
         rx_char <= 8'h00;
      end else begin
         rx_valid <= 1'b0;
         unique case (link_q)
            L_IDLE: if (wr && (cmd_kind == 4'h2 || cmd_kind == 4'h3) && ll_q) begin
               // Any modulation is accepted; no handshake is run
               link_q <= L_DATA; // [RULE2] [RULE3] [RULE4] [RULE23]
               orig_q <= (cmd_kind == 4'h2);
            end
            L_DATA: if (hangup_q && (dtr_f != dtr_prev)) link_q <= L_OK1; // [RULE5]
            L_OK1: if (rx_ready) begin
               rx_valid <= 1'b1;
               rx_char <= `RESP_OK;
               link_q <= L_OK2;
            end
            L_OK2: if (rx_ready) begin
               rx_valid <= 1'b1;
               rx_char <= `RESP_K;
               link_q <= L_OKCR;
            end
            L_OKCR: if (rx_ready) begin
               rx_valid <= 1'b1;
               rx_char <= `CHAR_CR;
               link_q <= L_DRAIN;
            end
            L_DRAIN: link_q <= L_IDLE; // [RULE5]
            default: link_q <= L_IDLE;
         endcase
      end
   end

   // RTS-gated carrier timing for half-duplex mode
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !hdx_q) begin
         gate_cnt_q <= 18'h00000;
         gate_up_q <= 1'b0;
      end else if (rts_f != gate_up_q) begin
         if ({14'h0000, gate_cnt_q} >= ((rts_f ? UP_CYC : OFF_CYC) - 1)) begin
            gate_up_q <= rts_f; // [RULE22]
            gate_cnt_q <= 18'h00000;
         end else begin
            gate_cnt_q <= gate_cnt_q + 18'h00001;
         end
      end else begin
         gate_cnt_q <= 18'h00000;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (sys_rst) carrier_q <= 1'b0;
      else carrier_q <= (link_q inside {L_DATA, L_OK1, L_OK2, L_OKCR}) && (!hdx_q || gate_up_q); // [RULE4] [RULE5]
   end

   // ----------------------------------------
   // Caller ID
   // ----------------------------------------
   cid_e cid_st_q;
   logic snoop;
   assign snoop = (cid_q == `CID_SNOOP);
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cid_st_q <= C_IDLE;
         hook_off <= 1'b0;
         dtmf_valid <= 1'b0;
         dtmf_digit <= 4'h0;
         cid_report <= 1'b0;
      end else begin
         dtmf_valid <= 1'b0;
         cid_report <= 1'b0;
         unique case (cid_st_q)
            C_IDLE: begin
               hook_off <= off_hook_req || (link_q != L_IDLE);
               if (cidx_q[`CID_TYPE2_BIT] && hook_off && alert_tone) begin // [RULE15]
                  dtmf_valid <= 1'b1; // [RULE16]
                  dtmf_digit <= `DTMF_D;
                  cid_st_q <= C_MSG;
               end else if (snoop && !hook_off && cid_msg_done) begin
                  cid_report <= 1'b1; // [RULE17] [RULE18]
               end
            end
            C_MSG: if (cid_msg_done) begin
               cid_report <= 1'b1;
               hook_off <= 1'b0; // [RULE16]
               cid_st_q <= C_TONE;
            end
            C_TONE: if (!off_hook_req) cid_st_q <= C_IDLE;
            default: cid_st_q <= C_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Ring detection and outputs
   // ----------------------------------------
   logic energy_sel;
   assign energy_sel = (ring_thr_q != 8'h00);
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ring_detect <= 1'b0;
         ring_freq_check <= 1'b0;
      end else begin
         ring_freq_check <= energy_sel && !ring_thr_q[`RING_FREQ_OFF_BIT]; // [RULE11]
         if (!energy_sel) ring_detect <= opto_f; // [RULE12]
         else ring_detect <= ring_energy_ok && (ring_thr_q[`RING_FREQ_OFF_BIT] || ring_freq_ok); // [RULE13]
      end
   end
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         data_mode <= 1'b0;
         tx_carrier <= 1'b0;
         originate <= 1'b0;
         carrier_detect <= 1'b0;
         cts <= 1'b0;
         tone_enable <= `ANS_TONE_DEF;
         modulation <= `MOD_DEF;
         retrain_thr <= `RETRAIN_THR_DEF;
         auto_retrain <= 1'b0;
         respond_retrain <= 1'b0;
         ring_lo <= `RING_FLO_DEF;
         ring_hi <= `RING_FHI_DEF;
         auto_answer_rings <= 8'h00;
      end else begin
         data_mode <= (link_q == L_DATA);
         tx_carrier <= carrier_q;
         originate <= orig_q;
         carrier_detect <= raw_cd_q ? raw_f : qual_carrier; // [RULE9]
         cts <= hdx_q ? gate_up_q : (!hwflow_q || clear_q || rx_ready); // [RULE10]
         tone_enable <= ans_tone_q & `ANS_TONE_VALID; // [RULE24]
         modulation <= mod_q; // [RULE8]
         retrain_thr <= rthr_q; // [RULE7]
         auto_retrain <= ropt_q[`RETRAIN_AUTO_BIT];
         respond_retrain <= resp_q;
         ring_lo <= rlo_q;
         ring_hi <= rhi_q;
         auto_answer_rings <= rings_q;
      end
   end
endmodule
`default_nettype wire

// ==== modem_line_mode_checker.sv ====
`include "line_mode_map.svh"
`default_nettype none
module modem_line_mode_checker (
   input wire logic ref_clk, // Clock
   input wire logic sys_rst, // Sync reset
   input wire logic cmd_valid, // Item strobe
   input wire logic [3:0] cmd_kind, // Item kind
   input wire logic [7:0] cmd_addr, // Register number
   input wire logic [7:0] cmd_data, // Value
   input wire logic data_mode, // Data mode
   input wire logic tx_carrier, // Carrier on
   input wire logic rx_valid, // Response strobe
   input wire logic [7:0] rx_char, // Response char
   input wire logic hook_off, // Off hook
   input wire logic dtmf_valid, // Digit strobe
   input wire logic [3:0] dtmf_digit, // Digit
   input wire logic ring_freq_check, // Freq check on
   input wire logic [7:0] tone_enable, // Tone enables
   input wire logic [7:0] modulation, // Modulation copy
   input wire logic [7:0] retrain_thr // Retrain threshold
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);
   logic reg_wr;
   assign reg_wr = cmd_valid && cmd_kind == 4'h0;
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_mod_write;
      reg_wr && cmd_addr == `REG_MODULATION |-> ##2 modulation == $past(cmd_data, 2);
   endproperty
   a_mod_write: assert property (p_mod_write) else $error("bad modulation");
   property p_thr_write;
      reg_wr && cmd_addr == `REG_RETRAIN_THR |-> ##2 retrain_thr == $past(cmd_data, 2);
   endproperty
   a_thr_write: assert property (p_thr_write) else $error("retrain threshold wrong");
   property p_tone_write;
      reg_wr && cmd_addr == `REG_ANS_TONE |-> ##2 tone_enable == ($past(cmd_data, 2) & `ANS_TONE_VALID);
   endproperty
   a_tone_write: assert property (p_tone_write) else $error("tone enables wrong");
   property p_tone_resv;
      (tone_enable & 8'hC8) == 8'h00;
   endproperty
   a_tone_resv: assert property (p_tone_resv) else $error("reserved tone bit set");
   property p_defaults;
      cmd_valid && cmd_kind == 4'h5 |-> ##[1:2] tone_enable == `ANS_TONE_DEF;
   endproperty
   a_defaults: assert property (p_defaults) else $error("tone defaults wrong");
   property p_ring_thr;
      reg_wr && cmd_addr == `REG_RING_THR && cmd_data != 8'h00 |-> ##2 ring_freq_check == !$past(cmd_data[7], 2);
   endproperty
   a_ring_thr: assert property (p_ring_thr) else $error("freq check wrong");
   property p_enter_data;
      $rose(data_mode) |-> $past(cmd_valid, 2) && ($past(cmd_kind, 2) == 4'h2 || $past(cmd_kind, 2) == 4'h3);
   endproperty
   a_enter_data: assert property (p_enter_data) else $error("bad data entry");
   property p_carrier_up;
      $rose(data_mode) |=> tx_carrier;
   endproperty
   a_carrier_up: assert property (p_carrier_up) else $error("carrier not started");
   property p_ok_chars;
      rx_valid |-> rx_char == `RESP_OK || rx_char == `RESP_K || rx_char == `CHAR_CR;
   endproperty
   a_ok_chars: assert property (p_ok_chars) else $error("bad response char");
   property p_carrier_stop;
      rx_valid && rx_char == `CHAR_CR |-> tx_carrier ##[1:3] !tx_carrier;
   endproperty
   a_carrier_stop: assert property (p_carrier_stop) else $error("carrier kept");
   property p_dtmf;
      dtmf_valid |-> dtmf_digit == `DTMF_D && hook_off;
   endproperty
   a_dtmf: assert property (p_dtmf) else $error("bad digit or on hook");
endmodule
`default_nettype wire

// ==== host_terminal_model.sv ====
`default_nettype none
module host_terminal_model (
   input wire logic clk, // Modem clock
   input wire logic rx_valid, // Response strobe
   input wire logic [7:0] rx_char, // Response char
   output logic cmd_valid, // Item strobe
   output logic [3:0] cmd_kind, // Item kind
   output logic [7:0] cmd_addr, // Register or option
   output logic [7:0] cmd_data, // Value
   output logic dtr_pin, // Terminal ready
   output logic rx_ready // Takes a response char
);
   timeunit 1ns;
   timeprecision 1ps;
   logic slow;
   logic [7:0] rx_q[$];
   initial begin
      slow = 1'b0;
      cmd_valid = 1'b0;
      cmd_kind = 4'h4;
      cmd_addr = 8'h00;
      cmd_data = 8'h00;
      dtr_pin = 1'b1;
      rx_ready = 1'b1;
   end
   // A slow host stalls every other char slot
   always @(negedge clk) rx_ready <= slow ? ~rx_ready : 1'b1;
   always @(posedge clk) if (rx_valid) rx_q.push_back(rx_char);
   // ----------------------------------------
   // Line items, one at a time in line order
   // ----------------------------------------
   task automatic send(input logic [3:0] k, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_kind = k;
      cmd_addr = a;
      cmd_data = d;
      @(negedge clk);
      cmd_valid = 1'b0;
      // Idle bus shows inverted address and data; cmd_kind keeps the last item kind
      cmd_addr = ~a;
      cmd_data = ~d;
   endtask
   task automatic toggle_dtr();
      @(negedge clk);
      dtr_pin = ~dtr_pin;
   endtask
endmodule
`default_nettype wire

// ==== modem_line_mode_control_tb.sv ====
`include "line_mode_map.svh"
`default_nettype none
module modem_line_mode_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] MODS [5] = '{8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cmd_valid, dtr_pin, rx_ready, rts_pin, raw_carrier_pin, qual_carrier, opto_ring_pin;
   logic ring_energy_ok, ring_freq_ok, alert_tone, cid_msg_done, off_hook_req;
   logic data_mode, tx_carrier, originate, carrier_detect, cts, rx_valid, hook_off, dtmf_valid;
   logic cid_report, ring_detect, ring_freq_check, auto_retrain, respond_retrain;
   logic [3:0] cmd_kind, dtmf_digit;
   logic [7:0] cmd_addr, cmd_data, rx_char, tone_enable, modulation, retrain_thr;
   logic [7:0] ring_lo, ring_hi, auto_answer_rings;
   logic [6:0] mon;
   int error_cnt = 0;
   int tests_run = 0;
   always #25 ref_clk = ~ref_clk;
   assign mon = {cid_report, dtmf_valid, hook_off, carrier_detect, ring_detect, tx_carrier, data_mode};
   modem_line_mode_control u_modem_line_mode_control (.ref_clk, .sys_rst, .cmd_valid, .cmd_kind, .cmd_addr,
      .cmd_data, .dtr_pin, .rts_pin, .raw_carrier_pin, .qual_carrier, .opto_ring_pin, .ring_energy_ok,
      .ring_freq_ok, .alert_tone, .cid_msg_done, .off_hook_req, .rx_ready, .data_mode, .tx_carrier, .originate,
      .carrier_detect, .cts, .rx_valid, .rx_char, .hook_off, .dtmf_valid, .dtmf_digit, .cid_report, .ring_detect,
      .ring_freq_check, .tone_enable, .modulation, .retrain_thr, .auto_retrain, .respond_retrain, .ring_lo,
      .ring_hi, .auto_answer_rings);
   host_terminal_model u_host_terminal_model (.clk(ref_clk), .rx_valid, .rx_char, .cmd_valid, .cmd_kind,
      .cmd_addr, .cmd_data, .dtr_pin, .rx_ready);
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic final_report();
      if (error_cnt == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Bounded wait on one watched output; a miss ends the run
   task automatic wait_val(input int idx, input logic exp, input int lim, input string nm);
      int i;
      for (i = 0; i < lim && mon[idx] !== exp; i++) @(negedge ref_clk);
      chk(nm, {7'h00, mon[idx]}, {7'h00, exp});
      if (mon[idx] !== exp) final_report();
   endtask
   task automatic cmd(input logic [3:0] k, input logic [7:0] a, input logic [7:0] d);
      u_host_terminal_model.send(k, a, d);
      repeat (2) @(negedge ref_clk);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      chk("tone_enable reset", tone_enable, `ANS_TONE_DEF);
      for (int i = 0; i < 5; i++) begin
         cmd(4'h0, `REG_MODULATION, MODS[i]);
         chk("modulation", modulation, MODS[i]);
      end
      cmd(4'h0, `REG_ANS_TONE, 8'hFF);
      chk("tone_enable all", tone_enable, 8'h37);
      cmd(4'h0, `REG_RETRAIN_THR, 8'h0C);
      chk("retrain_thr", retrain_thr, 8'h0C);
      cmd(4'h0, `REG_RETRAIN_OPT, 8'h04);
      chk("auto_retrain", {7'h00, auto_retrain}, 8'h01);
      cmd(4'h6, 8'h06, 8'h00);
      chk("respond_retrain", {7'h00, respond_retrain}, 8'h01);
      cmd(4'h0, `REG_COUNTRY, `COUNTRY_US);
      chk("country tone", tone_enable, `ANS_TONE_DEF);
      chk("country retrain", retrain_thr, `RETRAIN_THR_DEF);
      chk("country ring_lo", ring_lo, `RING_FLO_DEF);
      chk("country ring_hi", ring_hi, `RING_FHI_DEF);
      cmd(4'h0, `REG_ANS_TONE, 8'h02);
      chk("tone after country", tone_enable, 8'h02);
      cmd(4'h5, 8'h00, 8'h00);
      chk("tone defaults", tone_enable, `ANS_TONE_DEF);
   endtask
   task automatic t_ring();
      opto_ring_pin = 1'b1;
      cmd(4'h0, `REG_RING_THR, 8'h00);
      wait_val(2, 1'b1, 12, "ring_detect opto");
      opto_ring_pin = 1'b0;
      ring_energy_ok = 1'b1;
      ring_freq_ok = 1'b1;
      cmd(4'h0, `REG_RING_THR, 8'h07);
      cmd(4'h0, `REG_AUTO_ANS, 8'h01);
      chk("auto_answer_rings", auto_answer_rings, 8'h01);
      chk("ring_freq_check 7", {7'h00, ring_freq_check}, 8'h01);
      wait_val(2, 1'b1, 12, "ring_detect energy");
      ring_freq_ok = 1'b0;
      wait_val(2, 1'b0, 6, "ring_detect bad freq");
      cmd(4'h0, `REG_RING_THR, 8'h7F);
      chk("ring_freq_check 127", {7'h00, ring_freq_check}, 8'h01);
      cmd(4'h0, `REG_RING_THR, 8'h81);
      chk("ring_freq_check 129", {7'h00, ring_freq_check}, 8'h00);
      wait_val(2, 1'b1, 6, "ring_detect no freq check");
      ring_energy_ok = 1'b0;
   endtask
   // Leased-line session, hang up by terminal-ready toggle
   task automatic t_session(input logic [7:0] m, input logic [3:0] k, input logic orig, input logic slw);
      logic [7:0] resp [3];
      resp = '{`RESP_OK, `RESP_K, `CHAR_CR};
      u_host_terminal_model.send(4'h6, 8'h05, 8'h00);
      u_host_terminal_model.send(4'h0, `REG_MODULATION, m);
      u_host_terminal_model.send(4'h1, 8'h00, 8'h00);
      u_host_terminal_model.send(k, 8'h00, 8'h00);
      wait_val(0, 1'b1, 6, "data_mode");
      wait_val(1, 1'b1, 4, "tx_carrier");
      chk("originate", {7'h00, originate}, {7'h00, orig});
      u_host_terminal_model.rx_q.delete();
      u_host_terminal_model.slow = slw;
      u_host_terminal_model.toggle_dtr();
      wait_val(1, 1'b0, 80, "tx_carrier off");
      chk("resp count", 8'(u_host_terminal_model.rx_q.size()), 8'h03);
      for (int i = 0; i < 3 && i < u_host_terminal_model.rx_q.size(); i++) begin
         chk("resp char", u_host_terminal_model.rx_q[i], resp[i]);
      end
   endtask
   task automatic t_carrier();
      raw_carrier_pin = 1'b1;
      cmd(4'h6, 8'h00, 8'h00);
      wait_val(3, 1'b1, 12, "carrier_detect raw");
      cmd(4'h6, 8'h01, 8'h00);
      wait_val(3, 1'b0, 6, "carrier_detect qualified low");
      qual_carrier = 1'b1;
      wait_val(3, 1'b1, 4, "carrier_detect qualified");
      chk("cts", {7'h00, cts}, 8'h01);
   endtask
   task automatic t_cid();
      cmd(4'h0, `REG_CID_EXTRA, 8'h08);
      off_hook_req = 1'b1;
      wait_val(4, 1'b1, 4, "hook_off");
      alert_tone = 1'b1;
      @(negedge ref_clk);
      alert_tone = 1'b0;
      wait_val(5, 1'b1, 6, "dtmf_valid");
      chk("dtmf_digit", {4'h0, dtmf_digit}, {4'h0, `DTMF_D});
      cid_msg_done = 1'b1;
      @(negedge ref_clk);
      cid_msg_done = 1'b0;
      wait_val(4, 1'b0, 6, "hook_off after message");
      off_hook_req = 1'b0;
      cmd(4'h0, `REG_CID_CTRL, `CID_SNOOP);
      cid_msg_done = 1'b1;
      @(negedge ref_clk);
      cid_msg_done = 1'b0;
      wait_val(6, 1'b1, 6, "cid_report snoop");
      chk("snoop stays on hook", {7'h00, hook_off}, 8'h00);
   endtask
   initial begin
      {rts_pin, raw_carrier_pin, qual_carrier, opto_ring_pin, ring_energy_ok} = 5'h00;
      {ring_freq_ok, alert_tone, cid_msg_done, off_hook_req} = 4'h0;
      repeat (5) @(negedge ref_clk);
      sys_rst = 1'b0;
      @(negedge ref_clk);
      chk("data_mode reset", {7'h00, data_mode}, 8'h00);
      t_regs();
      t_ring();
      cmd(4'h2, 8'h00, 8'h00);
      repeat (4) @(negedge ref_clk);
      chk("dial without leased", {7'h00, data_mode}, 8'h00);
      t_session(`MOD_V22, 4'h3, 1'b0, 1'b1);
      t_session(`MOD_V21, 4'h2, 1'b1, 1'b0);
      t_carrier();
      t_cid();
      final_report();
   end
endmodule
bind modem_line_mode_control modem_line_mode_checker u_modem_line_mode_checker (.ref_clk, .sys_rst, .cmd_valid,
   .cmd_kind, .cmd_addr, .cmd_data, .data_mode, .tx_carrier, .rx_valid, .rx_char, .hook_off, .dtmf_valid,
   .dtmf_digit, .ring_freq_check, .tone_enable, .modulation, .retrain_thr);
`default_nettype wire
